// ==== dmag_top.sv ====
// Purpose: Data-memory address generation for a 4-bit core
// Assumes: Sequencer holds req for one cycle per access; inputs synchronous
// Notes: One cycle from req to ack; outputs registered
// Operation
// - Bit and nibble direct: 00-3F selects bank 0, 80-FF bank 15.
// - Byte direct: even operand; 00-3E bank 0, 80-FE bank 15.
// - Bit direct serves only bit set, clear, skip-true and skip-false.
// - Peripheral bit direct only where location supports bit manipulation.
// - Nibble direct serves transfer, exchange, increment-skip, port in, port out.
// - Byte direct serves transfer and exchange with accumulator pair only.
// - Peripheral byte direct only at addresses supporting byte manipulation.
// - Indirect nibble uses bank 0, RAM 000-03F; software keeps pointer there.
// - Pointer pair steps by increment-skip and decrement-skip.
// - Peripheral bit mode targets only FB0-FBF and FF0-FFF.
// - Peripheral bit mode adds AND, OR, XOR of carry with bit.
// - Test-and-clear tests bit, skips if set, clears it.
// - Stack uses bank 0, pointer top bits forced 001, 020-03F.
// - Stack serves context save and restore and pair push and pop.
// - Twelve-bit address: bank forms top four bits, operand low eight in the direct modes.
module dmag_top #(
   parameter logic [15:0] BIT_CAP_MAP = 16'hFFFF,
   parameter logic [7:0] BYTE_CAP_MAP = 8'hFF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic req,
   input wire dmag_pkg::dmag_mode_t mode,
   input wire dmag_pkg::dmag_op_t op,
   input wire logic [7:0] operand,
   input wire logic [1:0] bit_sel,
   input wire logic [7:0] acc_pair,
   input wire logic carry_in,
   input wire logic [3:0] rd_nibble,
   input wire logic pair_load,
   input wire logic [7:0] pair_load_value,
   input wire logic pair_low_only,
   input wire dmag_pkg::dmag_ptr_t pair_cmd,
   input wire logic sp_load,
   input wire logic [7:0] sp_load_value,
   output logic ack,
   output logic err,
   output logic [11:0] mem_addr,
   output logic [11:0] mem_addr_hi,
   output logic mem_wide,
   output logic mem_we,
   output logic [3:0] mem_wdata,
   output logic [3:0] mem_wdata_hi,
   output logic carry_out,
   output logic skip,
   output logic [7:0] indirect_pair,
   output logic [7:0] stack_pointer
);
   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   logic [11:0] map_addr;
   logic map_ok;
   logic ptr_skip;

   dmag_map u_map (
      .mode(mode),
      .operand(operand),
      .pair_value(indirect_pair),
      .stack_value(stack_pointer),
      .addr(map_addr),
      .in_range(map_ok)
   );

   dmag_ptr #(.W(8)) u_ptr (
      .clk(clk),
      .sys_rst(sys_rst),
      .load(pair_load),
      .load_value(pair_load_value),
      .low_only(pair_low_only),
      .cmd(pair_cmd),
      .value(indirect_pair),
      .skip(ptr_skip)
   );

   // ----------------------------------------------------------------
   // Legality decode
   // ----------------------------------------------------------------
   // Peripheral capability lookups; parameters stand for the unseen map
   function automatic logic peri_bit_ok(input logic [7:0] a);
      peri_bit_ok = (a >= dmag_pkg::FBIT_HI_FIRST) ? BIT_CAP_MAP[a[3:0]] : 1'b0;
   endfunction
   function automatic logic peri_byte_ok(input logic [7:0] a);
      peri_byte_ok = BYTE_CAP_MAP[a[6:4]];
   endfunction

   logic op_ok;
   logic cap_ok;
   logic is_bitop;

   assign is_bitop = op == dmag_pkg::DMAG_OP_BIT_SET || op == dmag_pkg::DMAG_OP_BIT_CLEAR
      || op == dmag_pkg::DMAG_OP_SKIP_TRUE || op == dmag_pkg::DMAG_OP_SKIP_FALSE;

   // Which operations each mode may carry
   always_comb begin
      op_ok = 1'b0;
      cap_ok = 1'b1;
      case (mode)
         dmag_pkg::DMAG_MODE_BIT: begin
            op_ok = is_bitop;
            cap_ok = operand <= dmag_pkg::RAM_LAST || peri_bit_ok(operand);
         end
         dmag_pkg::DMAG_MODE_NIB: begin
            op_ok = op == dmag_pkg::DMAG_OP_TRANSFER || op == dmag_pkg::DMAG_OP_EXCHANGE
               || op == dmag_pkg::DMAG_OP_INC_SKIP || op == dmag_pkg::DMAG_OP_PORT_IN
               || op == dmag_pkg::DMAG_OP_PORT_OUT;
         end
         dmag_pkg::DMAG_MODE_BYTE: begin
            op_ok = op == dmag_pkg::DMAG_OP_TRANSFER || op == dmag_pkg::DMAG_OP_EXCHANGE;
            cap_ok = operand <= dmag_pkg::RAM_LAST_EVEN || peri_byte_ok(operand);
         end
         dmag_pkg::DMAG_MODE_IND: begin
            op_ok = 1'b1;
         end
         dmag_pkg::DMAG_MODE_FBIT: begin
            op_ok = is_bitop || op == dmag_pkg::DMAG_OP_TEST_CLEAR
               || op == dmag_pkg::DMAG_OP_BOOL_AND || op == dmag_pkg::DMAG_OP_BOOL_OR
               || op == dmag_pkg::DMAG_OP_BOOL_XOR;
         end
         dmag_pkg::DMAG_MODE_STACK: begin
            op_ok = op == dmag_pkg::DMAG_OP_PUSH || op == dmag_pkg::DMAG_OP_POP
               || op == dmag_pkg::DMAG_OP_CONTEXT;
         end
         default: begin
            op_ok = 1'b0;
            cap_ok = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Access state
   // ----------------------------------------------------------------
   logic ack_q, ack_d;
   logic err_q, err_d;
   logic [11:0] addr_q, addr_d;
   logic [11:0] addr_hi_q, addr_hi_d;
   logic wide_q, wide_d;
   logic we_q, we_d;
   logic [3:0] wd_q, wd_d;
   logic [3:0] wd_hi_q, wd_hi_d;
   logic cy_q, cy_d;
   logic skip_q, skip_d;
   logic [7:0] sp_q, sp_d;
   logic legal;
   logic bit_val;
   logic [3:0] bit_mask;

   assign legal = map_ok & op_ok & cap_ok;
   assign bit_val = rd_nibble[bit_sel];
   assign bit_mask = 4'h1 << bit_sel;

   // Refused accesses still answer, with err and no write
   always_comb begin
      ack_d = req;
      err_d = req & ~legal;
      addr_d = addr_q;
      addr_hi_d = addr_hi_q;
      wide_d = 1'b0;
      we_d = 1'b0;
      wd_d = wd_q;
      wd_hi_d = wd_hi_q;
      cy_d = cy_q;
      skip_d = 1'b0;
      sp_d = sp_load ? sp_load_value : sp_q;
      if (req && legal) begin
         addr_d = map_addr;
         addr_hi_d = map_addr | 12'h001;
         wide_d = mode == dmag_pkg::DMAG_MODE_BYTE;
         case (op)
            dmag_pkg::DMAG_OP_BIT_SET: begin
               we_d = 1'b1;
               wd_d = rd_nibble | bit_mask;
            end
            dmag_pkg::DMAG_OP_BIT_CLEAR: begin
               we_d = 1'b1;
               wd_d = rd_nibble & ~bit_mask;
            end
            dmag_pkg::DMAG_OP_SKIP_TRUE: skip_d = bit_val;
            dmag_pkg::DMAG_OP_SKIP_FALSE: skip_d = ~bit_val;
            dmag_pkg::DMAG_OP_TEST_CLEAR: begin
               skip_d = bit_val;
               we_d = 1'b1;
               wd_d = rd_nibble & ~bit_mask;
            end
            dmag_pkg::DMAG_OP_BOOL_AND: cy_d = carry_in & bit_val;
            dmag_pkg::DMAG_OP_BOOL_OR: cy_d = carry_in | bit_val;
            dmag_pkg::DMAG_OP_BOOL_XOR: cy_d = carry_in ^ bit_val;
            dmag_pkg::DMAG_OP_TRANSFER, dmag_pkg::DMAG_OP_EXCHANGE,
            dmag_pkg::DMAG_OP_PORT_OUT, dmag_pkg::DMAG_OP_PUSH: begin
               we_d = 1'b1;
               wd_d = acc_pair[3:0];
               wd_hi_d = acc_pair[7:4];
            end
            dmag_pkg::DMAG_OP_INC_SKIP: begin
               we_d = 1'b1;
               wd_d = rd_nibble + 4'h1;
               skip_d = rd_nibble == 4'hF;
            end
            default: we_d = 1'b0;
         endcase
      end
   end

   // Registers only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         addr_q <= '0;
         addr_hi_q <= '0;
         wide_q <= 1'b0;
         we_q <= 1'b0;
         wd_q <= dmag_pkg::NIB_RESET;
         wd_hi_q <= dmag_pkg::NIB_RESET;
         cy_q <= 1'b0;
         skip_q <= 1'b0;
         sp_q <= dmag_pkg::STACK_RESET;
      end else begin
         ack_q <= ack_d;
         err_q <= err_d;
         addr_q <= addr_d;
         addr_hi_q <= addr_hi_d;
         wide_q <= wide_d;
         we_q <= we_d;
         wd_q <= wd_d;
         wd_hi_q <= wd_hi_d;
         cy_q <= cy_d;
         skip_q <= skip_d;
         sp_q <= sp_d;
      end
   end

   assign ack = ack_q;
   assign err = err_q;
   assign mem_addr = addr_q;
   assign mem_addr_hi = addr_hi_q;
   assign mem_wide = wide_q;
   assign mem_we = we_q;
   assign mem_wdata = wd_q;
   assign mem_wdata_hi = wd_hi_q;
   assign carry_out = cy_q;
   assign skip = skip_q | ptr_skip; // Pair step skip must not lag a cycle
   assign stack_pointer = sp_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_bank_low;
      @(posedge clk) disable iff (sys_rst)
      (req && legal && mode == dmag_pkg::DMAG_MODE_NIB && operand <= 8'h3F)
         |=> mem_addr[11:8] == 4'h0;
   endproperty
   a_bank_low: assert property (p_bank_low) else $error("nibble low operand not bank 0");
   property p_bank_high;
      @(posedge clk) disable iff (sys_rst)
      (req && legal && mode == dmag_pkg::DMAG_MODE_BIT && operand >= 8'h80)
         |=> mem_addr == {4'hF, $past(operand)};
   endproperty
   a_bank_high: assert property (p_bank_high) else $error("bit high operand not bank 15");
   property p_byte_odd;
      @(posedge clk) disable iff (sys_rst)
      (req && mode == dmag_pkg::DMAG_MODE_BYTE && operand[0]) |=> err && !mem_we;
   endproperty
   a_byte_odd: assert property (p_byte_odd) else $error("odd byte operand accepted");
   property p_bit_ops;
      @(posedge clk) disable iff (sys_rst)
      (req && mode == dmag_pkg::DMAG_MODE_BIT && op == dmag_pkg::DMAG_OP_BOOL_AND) |=> err;
   endproperty
   a_bit_ops: assert property (p_bit_ops) else $error("bit direct took boolean op");
   property p_byte_ops;
      @(posedge clk) disable iff (sys_rst)
      (req && mode == dmag_pkg::DMAG_MODE_BYTE && op == dmag_pkg::DMAG_OP_INC_SKIP) |=> err;
   endproperty
   a_byte_ops: assert property (p_byte_ops) else $error("byte direct took increment");
   property p_ind_bank;
      @(posedge clk) disable iff (sys_rst)
      (req && legal && mode == dmag_pkg::DMAG_MODE_IND) |=> mem_addr[11:6] == 6'h00;
   endproperty
   a_ind_bank: assert property (p_ind_bank) else $error("indirect left RAM");
   property p_fbit_range;
      @(posedge clk) disable iff (sys_rst)
      (req && mode == dmag_pkg::DMAG_MODE_FBIT && operand < 8'hB0) |=> err;
   endproperty
   a_fbit_range: assert property (p_fbit_range) else $error("peripheral bit outside range");
   property p_test_clear;
      @(posedge clk) disable iff (sys_rst)
      (req && legal && op == dmag_pkg::DMAG_OP_TEST_CLEAR)
         |=> skip == $past(bit_val) && mem_we && !mem_wdata[$past(bit_sel)];
   endproperty
   a_test_clear: assert property (p_test_clear) else $error("test and clear wrong");
   property p_stack;
      @(posedge clk) disable iff (sys_rst)
      (req && mode == dmag_pkg::DMAG_MODE_STACK) |=> mem_addr[11:5] == 7'h01 || err;
   endproperty
   a_stack: assert property (p_stack) else $error("stack outside 020-03F");
   property p_byte_pair;
      @(posedge clk) disable iff (sys_rst)
      (req && legal && mode == dmag_pkg::DMAG_MODE_BYTE && op == dmag_pkg::DMAG_OP_TRANSFER)
         |=> mem_wdata == $past(acc_pair[3:0]) && mem_wdata_hi == $past(acc_pair[7:4])
         && mem_addr_hi == mem_addr + 12'h001;
   endproperty
   a_byte_pair: assert property (p_byte_pair) else $error("byte pair order wrong");

   c_test_clear: cover property (@(posedge clk) req && legal
      && op == dmag_pkg::DMAG_OP_TEST_CLEAR);
   c_byte_peri: cover property (@(posedge clk) req && legal
      && mode == dmag_pkg::DMAG_MODE_BYTE && operand >= 8'h80);
   c_stack: cover property (@(posedge clk) req && mode == dmag_pkg::DMAG_MODE_STACK);
   c_refused: cover property (@(posedge clk) req && !legal);
endmodule

// ==== dmag_pkg.sv ====
// Purpose: Constants and types for data-memory address generation
// Assumes: 12-bit banked data space, bank 0 RAM and bank 15 peripherals
// Notes: Address offsets, mode and op codes, and the pointer, stack and nibble reset values live here
package dmag_pkg;
   // ----------------------------------------------------------------
   // Address layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int OPND_W = 8;
   localparam logic [3:0] BANK_RAM = 4'h0;
   localparam logic [3:0] BANK_PERI = 4'hF;
   localparam logic [7:0] RAM_LAST = 8'h3F;
   localparam logic [7:0] RAM_LAST_EVEN = 8'h3E;
   localparam logic [7:0] PERI_FIRST = 8'h80;
   localparam logic [7:0] PERI_LAST_EVEN = 8'hFE;
   localparam logic [7:0] FBIT_LO_FIRST = 8'hB0;
   localparam logic [7:0] FBIT_LO_LAST = 8'hBF;
   localparam logic [7:0] FBIT_HI_FIRST = 8'hF0;
   localparam logic [2:0] STACK_TOP_BITS = 3'h1;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] STACK_RESET = 8'h00;
   localparam logic [3:0] NIB_RESET = 4'h0;

   // ----------------------------------------------------------------
   // Addressing modes (one-hot)
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      DMAG_MODE_BIT = 6'h01,
      DMAG_MODE_NIB = 6'h02,
      DMAG_MODE_BYTE = 6'h04,
      DMAG_MODE_IND = 6'h08,
      DMAG_MODE_FBIT = 6'h10,
      DMAG_MODE_STACK = 6'h20
   } dmag_mode_t;

   // ----------------------------------------------------------------
   // Operations presented by the sequencer
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      DMAG_OP_BIT_SET = 4'h0,
      DMAG_OP_BIT_CLEAR = 4'h1,
      DMAG_OP_SKIP_TRUE = 4'h2,
      DMAG_OP_SKIP_FALSE = 4'h3,
      DMAG_OP_TEST_CLEAR = 4'h4,
      DMAG_OP_BOOL_AND = 4'h5,
      DMAG_OP_BOOL_OR = 4'h6,
      DMAG_OP_BOOL_XOR = 4'h7,
      DMAG_OP_TRANSFER = 4'h8,
      DMAG_OP_EXCHANGE = 4'h9,
      DMAG_OP_INC_SKIP = 4'hA,
      DMAG_OP_PORT_IN = 4'hB,
      DMAG_OP_PORT_OUT = 4'hC,
      DMAG_OP_PUSH = 4'hD,
      DMAG_OP_POP = 4'hE,
      DMAG_OP_CONTEXT = 4'hF
   } dmag_op_t;

   // Pointer update commands for the indirect pair
   typedef enum logic [2:0] {
      DMAG_PTR_HOLD = 3'h1,
      DMAG_PTR_INC = 3'h2,
      DMAG_PTR_DEC = 3'h4
   } dmag_ptr_t;
endpackage

// ==== dmag_map.sv ====
// Purpose: Pure bank and range decode for one operand and mode
// Assumes: Operand and pointer values are stable during the request
// Notes: Combinational; the caller registers the result
module dmag_map (
   input wire dmag_pkg::dmag_mode_t mode,
   input wire logic [7:0] operand,
   input wire logic [7:0] pair_value,
   input wire logic [7:0] stack_value,
   output logic [11:0] addr,
   output logic in_range
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic ram_hit;
   logic peri_hit;
   logic even_ok;
   logic fbit_hit;
   logic [7:0] stack_low;

   // Range helpers shared by the direct modes
   assign ram_hit = operand <= dmag_pkg::RAM_LAST;
   assign peri_hit = operand >= dmag_pkg::PERI_FIRST;
   assign even_ok = ~operand[0];
   assign fbit_hit = (operand >= dmag_pkg::FBIT_LO_FIRST && operand <= dmag_pkg::FBIT_LO_LAST)
      || operand >= dmag_pkg::FBIT_HI_FIRST;
   // Top bits forced so stack never leaves its window
   assign stack_low = {dmag_pkg::STACK_TOP_BITS, stack_value[4:0]};

   // Bank select follows mode and operand range
   always_comb begin
      addr = '0;
      in_range = 1'b0;
      case (mode)
         dmag_pkg::DMAG_MODE_BIT, dmag_pkg::DMAG_MODE_NIB: begin
            addr = {ram_hit ? dmag_pkg::BANK_RAM : dmag_pkg::BANK_PERI, operand};
            in_range = ram_hit | peri_hit;
         end
         dmag_pkg::DMAG_MODE_BYTE: begin
            addr = {ram_hit ? dmag_pkg::BANK_RAM : dmag_pkg::BANK_PERI, operand};
            in_range = even_ok & ((operand <= dmag_pkg::RAM_LAST_EVEN)
               | (peri_hit & operand <= dmag_pkg::PERI_LAST_EVEN));
         end
         dmag_pkg::DMAG_MODE_IND: begin
            addr = {dmag_pkg::BANK_RAM, 2'b00, pair_value[5:0]};
            in_range = pair_value <= dmag_pkg::RAM_LAST;
         end
         dmag_pkg::DMAG_MODE_FBIT: begin
            addr = {dmag_pkg::BANK_PERI, operand};
            in_range = fbit_hit;
         end
         dmag_pkg::DMAG_MODE_STACK: begin
            addr = {dmag_pkg::BANK_RAM, stack_low};
            in_range = 1'b1;
         end
         default: begin
            addr = '0;
            in_range = 1'b0;
         end
      endcase
   end
endmodule

// ==== dmag_ptr.sv ====
// Purpose: Indirect pointer pair with increment and decrement skip
// Assumes: Loads and steps never coincide in one cycle
// Notes: Skip flags on wrap to zero or to all ones
module dmag_ptr #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [W-1:0] load_value,
   input wire logic low_only,
   input wire dmag_pkg::dmag_ptr_t cmd,
   output logic [W-1:0] value,
   output logic skip
);
   // ----------------------------------------------------------------
   // Pointer state
   // ----------------------------------------------------------------
   logic [W-1:0] ptr_q, ptr_d;
   logic skip_q, skip_d;
   logic [3:0] low_next;

   // Next value; the low-only form wraps within the low nibble
   always_comb begin
      ptr_d = ptr_q;
      skip_d = 1'b0;
      low_next = ptr_q[3:0];
      if (load) begin
         ptr_d = load_value;
      end else if (cmd == dmag_pkg::DMAG_PTR_INC) begin
         low_next = ptr_q[3:0] + 4'h1;
         ptr_d = low_only ? {ptr_q[W-1:4], low_next} : ptr_q + W'(1);
         skip_d = low_only ? (low_next == 4'h0) : (ptr_d == '0);
      end else if (cmd == dmag_pkg::DMAG_PTR_DEC) begin
         low_next = ptr_q[3:0] - 4'h1;
         ptr_d = low_only ? {ptr_q[W-1:4], low_next} : ptr_q - W'(1);
         skip_d = low_only ? (low_next == 4'hF) : (ptr_d == '1);
      end
   end

   // Registers only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ptr_q <= dmag_pkg::PTR_RESET;
         skip_q <= 1'b0;
      end else begin
         ptr_q <= ptr_d;
         skip_q <= skip_d;
      end
   end

   assign value = ptr_q;
   assign skip = skip_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_ptr_inc;
      @(posedge clk) disable iff (sys_rst)
      (!load && cmd == dmag_pkg::DMAG_PTR_INC && !low_only) |=> value == $past(value) + W'(1);
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not increment");
   property p_ptr_dec;
      @(posedge clk) disable iff (sys_rst)
      (!load && cmd == dmag_pkg::DMAG_PTR_DEC && !low_only) |=> value == $past(value) - W'(1);
   endproperty
   a_ptr_dec: assert property (p_ptr_dec) else $error("pointer did not decrement");
endmodule

// ==== dmag_seq_model.sv ====
// Purpose: Sequencer model that presents data-memory accesses
// Assumes: Caller enters just after a rising edge plus the drive delay
// Notes: Request stays high across back-to-back issues; idle releases it
module dmag_seq_model (
   input wire logic clk,
   output logic req,
   output dmag_pkg::dmag_mode_t mode,
   output dmag_pkg::dmag_op_t op,
   output logic [7:0] operand,
   output logic [7:0] acc_pair
);
   // ----------------------------------------------------------------
   // Request driving
   // ----------------------------------------------------------------
   // Quiet bus at time zero
   initial begin
      req = 1'b0;
      mode = dmag_pkg::DMAG_MODE_NIB;
      op = dmag_pkg::DMAG_OP_TRANSFER;
      operand = 8'h00;
      acc_pair = 8'h00;
   end

   // Fields held unchanged through the sampling edge
   task automatic issue(input dmag_pkg::dmag_mode_t m, input dmag_pkg::dmag_op_t o,
      input logic [7:0] d, input logic [7:0] a);
      req = 1'b1;
      mode = m;
      op = o;
      operand = d;
      acc_pair = a;
      @(posedge clk);
      #1;
   endtask

   // Released fields change so a stale operand is never trusted
   task automatic idle();
      req = 1'b0;
      operand = ~operand;
      acc_pair = ~acc_pair;
      @(posedge clk);
      #1;
   endtask
endmodule

// ==== data_memory_address_gen_bench.sv ====
// Purpose: Self-checking bench for data-memory address generation
// Assumes: Default capability maps; one cycle from request to answer
// Notes: Expectations queue at issue time and are checked on ack
module data_memory_address_gen_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, req, carry_in, pair_load, pair_low_only, sp_load;
   logic ack, err, mem_wide, mem_we, carry_out, skip;
   logic [1:0] bit_sel;
   logic [3:0] rd_nibble, mem_wdata, mem_wdata_hi;
   logic [7:0] operand, acc_pair, pair_load_value, sp_load_value, indirect_pair, stack_pointer;
   logic [7:0] pv, sv;
   logic [11:0] mem_addr, mem_addr_hi;
   logic [12:0] e;
   logic [15:0] r;
   logic [12:0] exp_q[$];
   dmag_pkg::dmag_mode_t mode;
   dmag_pkg::dmag_op_t op;
   dmag_pkg::dmag_ptr_t pair_cmd;
   dmag_pkg::dmag_mode_t modes[5] = '{dmag_pkg::DMAG_MODE_BIT, dmag_pkg::DMAG_MODE_NIB,
      dmag_pkg::DMAG_MODE_BYTE, dmag_pkg::DMAG_MODE_FBIT, dmag_pkg::DMAG_MODE_STACK};
   logic [7:0] bnd[12] = '{8'h3E, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'h81, 8'hAF, 8'hB0,
      8'hBF, 8'hEF, 8'hF0, 8'hFF};
   int n_fail = 0;
   int comparisons = 0;

   dmag_top u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .mode(mode), .op(op),
      .operand(operand), .bit_sel(bit_sel), .acc_pair(acc_pair), .carry_in(carry_in),
      .rd_nibble(rd_nibble), .pair_load(pair_load), .pair_load_value(pair_load_value),
      .pair_low_only(pair_low_only), .pair_cmd(pair_cmd), .sp_load(sp_load),
      .sp_load_value(sp_load_value), .ack(ack), .err(err), .mem_addr(mem_addr),
      .mem_addr_hi(mem_addr_hi), .mem_wide(mem_wide), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .mem_wdata_hi(mem_wdata_hi), .carry_out(carry_out),
      .skip(skip), .indirect_pair(indirect_pair), .stack_pointer(stack_pointer));
   dmag_seq_model u_seq (.clk(clk), .req(req), .mode(mode), .op(op), .operand(operand),
      .acc_pair(acc_pair));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Clock at 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Expected refusal flag and address, from the bench's own pointer copies
   function automatic logic [12:0] expect_of(input logic [5:0] m, input logic [3:0] o,
      input logic [7:0] d);
      logic ok;
      logic [3:0] b;
      b = (d >= 8'h80) ? 4'hF : 4'h0;
      ok = (d <= 8'h3F) || (d >= 8'h80);
      case (m)
         6'h01: ok = ok && o <= 4'h3 && (d <= 8'h3F || d >= 8'hF0);
         6'h02: ok = ok && o >= 4'h8 && o <= 4'hC;
         6'h04: ok = ok && (o == 4'h8 || o == 4'h9) && !d[0];
         6'h08: begin
            ok = pv <= 8'h3F;
            b = 4'h0;
            d = pv;
         end
         6'h10: begin
            ok = o <= 4'h7 && (d[7:4] == 4'hB || d[7:4] == 4'hF);
            b = 4'hF;
         end
         default: begin
            ok = o >= 4'hD;
            b = 4'h0;
            d = {3'b001, sv[4:0]};
         end
      endcase
      return {!ok, b, d};
   endfunction

   task automatic chk(input logic c, input string msg);
      comparisons++;
      if (c !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task automatic go(input dmag_pkg::dmag_mode_t m, input logic [3:0] o, input logic [7:0] d,
      input logic [7:0] a);
      r = nx(r);
      bit_sel = r[1:0];
      carry_in = r[2];
      rd_nibble = r[7:4];
      exp_q.push_back(expect_of(m, o, d));
      u_seq.issue(m, dmag_pkg::dmag_op_t'(o), d, a);
   endtask

   // Pointer load or step lasting one edge, after one quiet edge
   task automatic ptr(input logic pl, input logic sl, input logic [7:0] v,
      input dmag_pkg::dmag_ptr_t c);
      @(posedge clk);
      #1;
      pair_load = pl;
      sp_load = sl;
      pair_load_value = v;
      sp_load_value = v;
      pair_cmd = c;
      @(posedge clk);
      #1;
      pair_load = 1'b0;
      sp_load = 1'b0;
      pair_cmd = dmag_pkg::DMAG_PTR_HOLD;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Result monitor
   // ----------------------------------------------------------------
   // Sampled after the edge so registered answers have landed
   always @(posedge clk) begin
      #2;
      if (ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "answer without request");
         end else begin
            e = exp_q.pop_front();
            chk(err === e[12], "refusal flag");
            if (!e[12]) chk(mem_addr === e[11:0], "address");
            else chk(mem_we === 1'b0, "write on refusal");
         end
      end
   end

   // Hang guard, far beyond the few hundred cycles of the sequence
   initial begin
      #16000;
      n_fail++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      {carry_in, pair_load, pair_low_only, sp_load, bit_sel, rd_nibble} = '0;
      pair_load_value = 8'h00;
      sp_load_value = 8'h00;
      pair_cmd = dmag_pkg::DMAG_PTR_HOLD;
      r = 16'h0003;
      pv = 8'h00;
      sv = 8'h00;
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      chk(ack === 1'b0 && indirect_pair === 8'h00 && stack_pointer === 8'h00, "reset");
      // Range edges of every direct mode, back to back
      foreach (bnd[i]) begin
         go(dmag_pkg::DMAG_MODE_BIT, 4'h0, bnd[i], 8'h00);
         go(dmag_pkg::DMAG_MODE_NIB, 4'h9, bnd[i], 8'h00);
         go(dmag_pkg::DMAG_MODE_BYTE, 4'h9, bnd[i], 8'h00);
         go(dmag_pkg::DMAG_MODE_FBIT, 4'h7, bnd[i], 8'h00);
      end
      // Every operation against every mode except indirect
      foreach (modes[m]) for (int o = 0; o < 16; o++) go(modes[m], o[3:0], 8'hF4, 8'h00);
      u_seq.idle();
      // Byte write pairs nibbles on even and odd addresses
      go(dmag_pkg::DMAG_MODE_BYTE, 4'h8, 8'h20, 8'h5A);
      chk(mem_we === 1'b1 && mem_wide === 1'b1 && mem_addr_hi === 12'h021, "byte pair");
      chk(mem_wdata === 4'hA && mem_wdata_hi === 4'h5, "byte data");
      go(dmag_pkg::DMAG_MODE_FBIT, 4'h7, 8'hF0, 8'h00);
      chk(carry_out === (carry_in ^ rd_nibble[bit_sel]), "carry");
      u_seq.idle();
      // Stack pointer outside the window still lands in 020-03F
      sv = 8'hE7;
      ptr(1'b0, 1'b1, sv, dmag_pkg::DMAG_PTR_HOLD);
      go(dmag_pkg::DMAG_MODE_STACK, 4'hD, 8'h00, 8'h00);
      u_seq.idle();
      // Indirect pointer at the top of RAM, then stepped past it
      pv = 8'h3F;
      ptr(1'b1, 1'b0, pv, dmag_pkg::DMAG_PTR_HOLD);
      go(dmag_pkg::DMAG_MODE_IND, 4'h8, 8'h00, 8'h00);
      u_seq.idle();
      ptr(1'b0, 1'b0, 8'h00, dmag_pkg::DMAG_PTR_INC);
      pv = 8'h40;
      chk(indirect_pair === pv && skip === 1'b0, "pointer step");
      go(dmag_pkg::DMAG_MODE_IND, 4'h8, 8'h00, 8'h00);
      u_seq.idle();
      // Wrap in both directions raises skip
      ptr(1'b1, 1'b0, 8'hFF, dmag_pkg::DMAG_PTR_HOLD);
      ptr(1'b0, 1'b0, 8'h00, dmag_pkg::DMAG_PTR_INC);
      chk(indirect_pair === 8'h00 && skip === 1'b1, "increment wrap");
      ptr(1'b0, 1'b0, 8'h00, dmag_pkg::DMAG_PTR_DEC);
      chk(indirect_pair === 8'hFF && skip === 1'b1, "decrement wrap");
      // Random operands and operations
      for (int i = 0; i < 200; i++) go(modes[r[10:8] % 5], r[3:0], r[15:8], r[7:0]);
      u_seq.idle();
      repeat (3) @(posedge clk);
      chk(exp_q.size() == 0, "missing answers");
      conclude();
   end
endmodule
